// >>> core/osc_consts.vh
// Register map, field layout, reset values and timing figures of the clock select block.
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define OSC_IDX_MODE        8'h03
`define OSC_IDX_XTAL        8'h0A
`define OSC_IDX_STATUS      8'h10
`define OSC_ADDR_W          8

// Mode register fields.
`define OSC_MODE_SEL_HI     7
`define OSC_MODE_SEL_LO     5
`define OSC_MODE_FAST_EN    4
`define OSC_MODE_TYPE       3
`define OSC_MODE_SLOW_EN    2
`define OSC_MODE_WDT_EN     1
`define OSC_MODE_RST_PIN    0
`define OSC_MODE_RESET      8'hF6

// Crystal setup register fields.
`define OSC_XTAL_EN         7
`define OSC_XTAL_DRV_HI     6
`define OSC_XTAL_DRV_LO     5
`define OSC_XTAL_RESET      3'h0

// Clock source codes.
`define OSC_SRC_FAST        2'h0
`define OSC_SRC_XTAL        2'h1
`define OSC_SRC_SLOW        2'h2

// Timing figures.
`define OSC_PCLK_HZ         40000000
`define OSC_XTAL_MIN_HZ     32000
`define OSC_XTAL_MAX_HZ     4000000
`define OSC_XTAL_MIN_CYC    (`OSC_PCLK_HZ / `OSC_XTAL_MAX_HZ)

`endif

// >>> core/osc_sysclk_select.v
// Oscillator enables and glitch-free system clock source and divider selection.
`timescale 1ns/1ps
`include "osc_consts.vh"

// Function
// R1: Crystal, fast RC and slow RC each have their own independent enable bit.
// R2: Crystal enable is write-only, resets to 0, 1 enables the crystal.
// R3: Crystal drive bits are write-only, reset 00; 01 low, 10 middle, 11 high.
// R4: Software writes zero to the low five crystal setup bits; they do nothing.
// R5: Crystal path supports 32 kHz to 4 MHz; faster is unsupported.
// R6: Software waits for the crystal to settle before selecting it.
// R7: Software turns the crystal off before power-down.
// R8: Software sets both crystal pins as inputs without pull-ups or digital buffers.
// R9: Mode bit 3 resets to 0 and picks the select encoding table.
// R10: Type 0 select codes map to fast RC, crystal and slow RC with dividers.
// R11: Type 1 select codes map to larger dividers; unlisted codes are reserved.
// R12: Mode bit 4 is read-write, resets to 1, enables the fast RC.
// R13: Mode bit 2 resets to 1, enables slow RC; off also stops the watchdog.
// R14: Mode bit 1 is read-write, resets to 1, enables the watchdog.
// R15: Mode bit 0 resets to 0; 1 makes the shared pin the external reset.
// R16: Software never switches away from a source and disables it in one write.
// R17: Source or divider changes never produce truncated system clock pulses.
module osc_sysclk_select #(
   parameter XTAL_MIN_CYC = `OSC_XTAL_MIN_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        fast_internal_rc,
   input  wire        slow_internal_rc,
   input  wire        crystal_pin_in,
   input  wire        external_reset_pin_n,
   output reg         crystal_enable,
   output reg  [1:0]  crystal_drive,
   output reg         fast_rc_enable,
   output reg         slow_rc_enable,
   output reg         watchdog_enable,
   output reg         reset_pin_select,
   output reg         port_a_bit5_in,
   output reg         external_reset_req,
   output reg         sys_clk_en
);

   reg  [7:0]  clock_mode_select;
   reg  [2:0]  crystal_setup;
   reg  [2:0]  osc_meta;
   reg  [2:0]  osc_sync;
   reg  [2:0]  osc_last;
   reg         pin_meta;
   reg         pin_sync;
   reg  [1:0]  active_src;
   reg  [2:0]  active_lg;
   reg  [5:0]  div_cnt;
   reg  [7:0]  xtal_gap;
   reg         xtal_overspeed;
   reg         sel_reserved;
   wire [2:0]  osc_tick;
   wire [5:0]  req;
   wire        req_valid;
   wire [1:0]  req_src;
   wire [2:0]  req_lg;
   wire        src_tick;
   wire        period_end;
   wire        setup_phase;
   wire        wr_done;
   wire [9:0]  word_idx;
   wire        hit_mode;
   wire        hit_xtal;
   wire        hit_status;
   wire [31:0] status_word;
   wire        hit_any;
   wire        bad_dir;
   wire [7:0]  gap_limit;
   reg  [31:0] next_prdata;

   // Returns {valid, source, log2 of divider} for a select code and table type.
   function [5:0] decode_sel;
      input       tbl;
      input [2:0] sel;
      begin
         decode_sel = 6'h00;
         if (!tbl) begin // R10
            case (sel)
               3'h0: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h2};
               3'h1: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h1};
               3'h3: decode_sel = {1'b1, `OSC_SRC_XTAL, 3'h2};
               3'h4: decode_sel = {1'b1, `OSC_SRC_XTAL, 3'h1};
               3'h5: decode_sel = {1'b1, `OSC_SRC_XTAL, 3'h0};
               3'h6: decode_sel = {1'b1, `OSC_SRC_SLOW, 3'h2};
               3'h7: decode_sel = {1'b1, `OSC_SRC_SLOW, 3'h0};
               default: decode_sel = 6'h00;
            endcase
         end else begin // R11
            case (sel)
               3'h0: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h4};
               3'h1: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h3};
               3'h2: decode_sel = {1'b1, `OSC_SRC_SLOW, 3'h4};
               3'h3: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h5};
               3'h4: decode_sel = {1'b1, `OSC_SRC_FAST, 3'h6};
               3'h5: decode_sel = {1'b1, `OSC_SRC_XTAL, 3'h3};
               default: decode_sel = 6'h00;
            endcase
         end
      end
   endfunction

   // Bus decode: one aligned word per register, a fixed answer with no wait states.
   assign setup_phase = psel & ~penable;
   assign wr_done     = psel & penable & pready & pwrite & ~pslverr;
   assign word_idx    = paddr[11:2];
   assign hit_mode    = (word_idx == {2'h0, `OSC_IDX_MODE});
   assign hit_xtal    = (word_idx == {2'h0, `OSC_IDX_XTAL});
   assign hit_status  = (word_idx == {2'h0, `OSC_IDX_STATUS});
   assign hit_any     = hit_mode | hit_xtal | hit_status;
   // Status is read-only and the crystal setup is write-only; the wrong direction is refused.
   assign bad_dir     = (pwrite & hit_status) | (~pwrite & hit_xtal);

   // Status word: overspeed, reserved request, active divider, active source, oscillator levels.
   assign status_word = {22'h000000, xtal_overspeed, sel_reserved, active_lg, active_src,
                         osc_sync};

   // The crystal setup register is write-only and reads back as zero.
   always @* begin
      next_prdata = 32'h00000000;
      if (hit_mode) begin
         next_prdata = {24'h000000, clock_mode_select};
      end else if (hit_status) begin
         next_prdata = status_word;
      end
   end

   // Every access is answered in the cycle after its setup, so ready is one registered pulse.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

   // The error flag stands only in the access cycle, alongside ready.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         pslverr <= ~hit_any | bad_dir;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Read data is captured at setup so that it is settled for the whole access cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
   end

   // A write lands only in the access cycle and only when the low byte lane is enabled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_mode_select <= `OSC_MODE_RESET; // R9 R12 R13 R14 R15
      end else if (wr_done && pstrb[0] && hit_mode) begin
         clock_mode_select <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_setup <= `OSC_XTAL_RESET; // R2 R3
      end else if (wr_done && pstrb[0] && hit_xtal) begin
         // Only the enable and drive bits are stored; the low bits are dropped.
         crystal_setup <= pwdata[`OSC_XTAL_EN:`OSC_XTAL_DRV_LO]; // R4
      end
   end

   // Control outputs follow their register bits one cycle later.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_enable <= 1'b0;
      end else begin
         crystal_enable <= crystal_setup[2]; // R1 R2
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_drive <= 2'h0;
      end else begin
         crystal_drive <= crystal_setup[1:0]; // R3
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_rc_enable <= 1'b1;
      end else begin
         fast_rc_enable <= clock_mode_select[`OSC_MODE_FAST_EN]; // R1 R12
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_rc_enable <= 1'b1;
      end else begin
         slow_rc_enable <= clock_mode_select[`OSC_MODE_SLOW_EN]; // R1 R13
      end
   end

   // The watchdog runs from the slow RC, so it must never be enabled without it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_enable <= 1'b1;
      end else begin
         watchdog_enable <= clock_mode_select[`OSC_MODE_WDT_EN] &
                            clock_mode_select[`OSC_MODE_SLOW_EN]; // R13 R14
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_pin_select <= 1'b0;
      end else begin
         reset_pin_select <= clock_mode_select[`OSC_MODE_RST_PIN]; // R15
      end
   end

   // The shared pin is synchronised first; its idle level is high, so reset loads ones.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= external_reset_pin_n;
         pin_sync <= pin_meta;
      end
   end

   // Shared pin: port bit 5 input or active-low external reset request.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_bit5_in     <= 1'b0;
         external_reset_req <= 1'b0;
      end else begin
         port_a_bit5_in     <= ~clock_mode_select[`OSC_MODE_RST_PIN] & pin_sync; // R15
         external_reset_req <= clock_mode_select[`OSC_MODE_RST_PIN] & ~pin_sync; // R15
      end
   end

   // Oscillator inputs are synchronised, then rising edges become tick pulses.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gen_osc
         wire raw;
         assign raw = (g == 0) ? fast_internal_rc :
                      (g == 1) ? crystal_pin_in : slow_internal_rc;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               osc_meta[g] <= 1'b0;
               osc_sync[g] <= 1'b0;
               osc_last[g] <= 1'b0;
            end else begin
               osc_meta[g] <= raw;
               osc_sync[g] <= osc_meta[g];
               osc_last[g] <= osc_sync[g];
            end
         end
         assign osc_tick[g] = osc_sync[g] & ~osc_last[g];
      end
   endgenerate

   // Gap counts between crystal edges below this limit mean a crystal above the supported range.
   assign gap_limit = XTAL_MIN_CYC[7:0] - 8'h01;

   // Gap counter between crystal edges; it saturates so that a slow crystal cannot wrap it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_gap <= 8'h00;
      end else if (!crystal_setup[2] || osc_tick[1]) begin
         xtal_gap <= 8'h00;
      end else if (xtal_gap != 8'hFF) begin
         xtal_gap <= xtal_gap + 8'h01;
      end
   end

   // The overspeed flag is sticky and is cleared only by disabling the crystal.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_overspeed <= 1'b0;
      end else if (!crystal_setup[2]) begin
         xtal_overspeed <= 1'b0;
      end else if (osc_tick[1] && xtal_gap != 8'h00 && xtal_gap < gap_limit) begin
         xtal_overspeed <= 1'b1; // R5
      end
   end

   assign req        = decode_sel(clock_mode_select[`OSC_MODE_TYPE], // R9
                                  clock_mode_select[`OSC_MODE_SEL_HI:`OSC_MODE_SEL_LO]);
   assign req_valid  = req[5];
   assign req_src    = req[4:3];
   assign req_lg     = req[2:0];
   assign src_tick   = osc_tick[active_src];
   assign period_end = src_tick && (div_cnt == ((6'h01 << active_lg) - 6'h01));

   // A new source or divider is taken only at the end of a whole output period.
   // If the old source has stopped, no period ends and the switch waits for it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_src <= `OSC_SRC_SLOW;
         active_lg  <= 3'h0;
         div_cnt    <= 6'h00;
      end else if (period_end) begin
         div_cnt <= 6'h00;
         if (req_valid) begin
            active_src <= req_src; // R17
            active_lg  <= req_lg; // R17
         end
      end else if (src_tick) begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   // One enable pulse per finished period of the active source and divider.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_clk_en <= 1'b0;
      end else begin
         sys_clk_en <= period_end; // R17
      end
   end

   // Reserved codes are flagged and leave the running selection untouched.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reserved <= 1'b0;
      end else begin
         sel_reserved <= ~req_valid; // R10 R11
      end
   end

endmodule

// >>> test/osc_chk_asserts.sv
// Port-level assertions for the clock select block.
`timescale 1ns/1ps
module osc_chk_asserts #(parameter XTAL_MIN_CYC = 10) (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        pready,
   input logic        pslverr,
   input logic        crystal_enable,
   input logic [1:0]  crystal_drive,
   input logic        slow_rc_enable,
   input logic        watchdog_enable,
   input logic        reset_pin_select,
   input logic        port_a_bit5_in,
   input logic        external_reset_req,
   input logic        sys_clk_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence xtal_acc_s;
      psel && penable && pready && paddr == 12'h028;
   endsequence
   sequence xtal_wr_s;
      xtal_acc_s ##0 (pwrite && pstrb[0] && !pslverr);
   endsequence
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   xtal_store_a: assert property (xtal_wr_s |-> ##2 crystal_enable == $past(pwdata[7], 2)
      && crystal_drive == $past(pwdata[6:5], 2)) else $error("crystal setup not stored");
   xtal_wo_a: assert property (xtal_acc_s ##0 !pwrite |-> pslverr) else $error("read taken");
   wdt_slow_a: assert property (watchdog_enable |-> slow_rc_enable) else $error("wdt on");
   pin_port_a: assert property (reset_pin_select |-> !port_a_bit5_in) else $error("pin");
   pin_reset_a: assert property (external_reset_req |-> reset_pin_select) else $error("rst");
   clk_pulse_a: assert property (sys_clk_en |=> !sys_clk_en) else $error("clock pulse");
endmodule

bind osc_sysclk_select osc_chk_asserts #(.XTAL_MIN_CYC(XTAL_MIN_CYC)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
   .crystal_enable(crystal_enable), .crystal_drive(crystal_drive),
   .slow_rc_enable(slow_rc_enable), .watchdog_enable(watchdog_enable),
   .reset_pin_select(reset_pin_select), .port_a_bit5_in(port_a_bit5_in),
   .external_reset_req(external_reset_req), .sys_clk_en(sys_clk_en));

// >>> test/osc_xtal_model.sv
// Crystal model: a square wave on the crystal input once started, flat while stopped.
`timescale 1ns/1ps
module osc_xtal_model #(parameter HALF = 6, parameter START = 40) (
   input  logic       pclk,
   input  logic       enable,
   input  logic [1:0] drive,
   output logic       pin
);
   int age = 0;
   int ph = 0;
   initial pin = 1'b0;
   // Half period of 6 pclk keeps the crystal below 4 MHz.
   always @(posedge pclk) begin
      if (!enable || drive == 2'h0) begin
         age <= 0;
         pin <= 1'b0;
      end else if (age < START) begin
         age <= age + 1;
      end else begin
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
         if (ph == HALF - 1) pin <= ~pin;
      end
   end
endmodule

// >>> test/test_osc_and_sysclk_select.sv
// Bench: register access, pin function and system clock periods.
`timescale 1ns/1ps
module test_osc_and_sysclk_select;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, fast = 0, slow = 0, xtal, pin_n = 1;
   logic        xen, fen, sen, wen, rsel, pa5, rreq, sce;
   logic [1:0]  drv;
   int          num_errors = 0, num_checks = 0, n, fc = 0, sc = 0;
   logic [3:0]  tab [15] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hB, 4'hC, 4'hE,
                             4'h3, 4'h4, 4'h5, 4'hD, 4'h6, 4'hA, 4'h7};
   int          per [15] = '{32, 16, 16, 128, 64, 256, 512, 512, 48, 24, 12, 96, 80, 320, 20};
   osc_sysclk_select #(.XTAL_MIN_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_internal_rc(fast), .slow_internal_rc(slow), .crystal_pin_in(xtal),
      .external_reset_pin_n(pin_n), .crystal_enable(xen), .crystal_drive(drv),
      .fast_rc_enable(fen), .slow_rc_enable(sen), .watchdog_enable(wen),
      .reset_pin_select(rsel), .port_a_bit5_in(pa5), .external_reset_req(rreq),
      .sys_clk_en(sce));
   osc_xtal_model xtal_u (.pclk(pclk), .enable(xen), .drive(drv), .pin(xtal));
   initial forever #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      fc <= fen ? (fc + 1) % 8 : 0;
      sc <= sen ? (sc + 1) % 20 : 0;
      fast <= fen && fc < 4;
      slow <= sen && sc < 10;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic err);
      xfer(1'b0, a, 8'h00);
      if (!err) chk(prdata, {24'h0, exp});
      chk(pslverr, err);
   endtask
   task automatic wrs(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
      repeat (3) @(posedge pclk);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h00C, 8'hF6, 1'b0);
      rd(12'h028, 8'h00, 1'b1);
      chk({xen, drv, fen, sen, wen, rsel}, 7'h0E);
      for (int d = 0; d < 4; d++) begin
         wrs(12'h028, {d != 0, d[1:0], 5'h00});
         chk({xen, drv}, {d != 0, d[1:0]});
      end
      $display("test crystal setup done");
      pin_n <= 1'b0;
      wrs(12'h00C, 8'hF7);
      chk({rreq, pa5, rsel}, 3'b101);
      pin_n <= 1'b1;
      wrs(12'h00C, 8'h16);
      chk({rreq, pa5, rsel}, 3'b010);
      wrs(12'h00C, 8'h12);
      chk({wen, sen, fen}, 3'b001);
      wrs(12'h00C, 8'h14);
      chk({wen, sen}, 2'b01);
      rd(12'h00C, 8'h14, 1'b0);
      pstrb <= 4'h0;
      wrs(12'h00C, 8'h00);
      pstrb <= 4'hF;
      rd(12'h00C, 8'h14, 1'b0);
      $display("test mode bits done");
      for (int i = 0; i < 15; i++) begin
         xfer(1'b1, 12'h00C, {tab[i][2:0], 1'b1, tab[i][3], 3'b110});
         repeat (4) begin
            n = 0;
            do begin @(posedge pclk); n++; end while (sce !== 1'b1 && n < 3000);
         end
         chk(n, per[i]);
         xfer(1'b0, 12'h040, 8'h00);
         chk(prdata[8], tab[i] == 4'h2 || tab[i] == 4'hE);
      end
      $display("test clock select done");
      xfer(1'b0, 12'h040, 8'h00);
      chk(prdata[9:3], 7'h02);
      end_sim;
   end
endmodule
